// File: logic/scs_compensation_engine.sv
// Purpose: Gain/offset DAC codes, signal correction, alarm, steering
// Assumes: Digitised inputs synchronous to pclk, APB slave, no wait
// Notes:   Registered outputs recomputed every cycle, one cycle latency; APB outputs are combinational
// Functional notes
// - Continuously recompute gain and offset codes from store, four temp gaps.
// - First temp gap: gain is fixed gain minus coeff1 times (T1 minus temp).
// - Gap two adds coeff2 times excess; gaps three, four accumulate.
// - Fixed gain is ten bits from stored bytes 3 and 17.
// - Fixed offset is ten bits from stored bytes 4 and 17.
// - Offset code uses the same piecewise scheme with offset coefficients.
// - Coarse gain and coarse offset selections come from byte 2.
// - Digital mode: first range output is signal times slope plus ordinate.
// - Ranges two to five: (signal minus breakpoint) times slope plus ordinate.
// - Slopes are twelve bits: sign, unity bit, ten fraction bits.
// - Breakpoints are ten bits, stored high byte then low byte.
// - Upper gap-count nibble selects signal gaps: F,E,C,A,8,6.
// - Lower gap-count nibble selects temperature gaps: 0,5,8,11.
// - Alarm forces low or high output when source passes triggers.
// - Alarm levels are eight bits, compared to upper eight signal bits.
// - Byte 31 upper nibble selects alarm source signal.
// - Level steering drives aux pins showing level against three thresholds.
// - Level steering and alarm never active together.
// - Steering control byte matches alarm control byte format.
// - Filtered temperature moves by difference over two to the shift.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`default_nettype none
module scs_compensation_engine (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [scs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      temp_valid,
  input  wire logic [9:0]                temperature_signal,
  input  wire logic [9:0]                amplifier_signal,
  input  wire logic [9:0]                ground_reference_signal,
  input  wire logic [9:0]                voltage_output_signal,
  input  wire logic [9:0]                aux_one_level,
  input  wire logic [9:0]                aux_two_level,
  output logic      [9:0]                gain_dac,
  output logic      [9:0]                offset_dac,
  output logic      [2:0]                coarse_gain_sel,
  output logic      [4:0]                coarse_offset_sel,
  output logic      [9:0]                corrected_out,
  output logic                           alarm_active,
  output logic                           aux_pin_one_out,
  output logic                           aux_pin_one_oe,
  output logic                           aux_pin_two_out,
  output logic                           aux_pin_two_oe
);
  import scs_pkg::*;

  // ==========================================================
  // Coefficient store and APB slave
  logic [7:0]  store [STORE_DEPTH];
  logic [15:0] filt;
  logic        filt_primed;

  wire         access   = psel & penable;
  wire         in_store = paddr < ADDR_W'(STORE_DEPTH * 4);
  wire         is_stat0 = paddr == ADDR_STAT0;
  wire         is_stat1 = paddr == ADDR_STAT1;
  wire  [5:0]  widx     = paddr[7:2];
  wire         wr_store = access & pwrite & in_store;

  // Zero-wait slave; status words are read-only, writes ignored
  assign pready  = 1'b1;
  assign pslverr = access & ~(in_store | is_stat0 | is_stat1);
  assign prdata  = in_store ? {24'h000000, store[widx]}
                 : is_stat0 ? {6'h00, offset_dac, 6'h00, gain_dac}
                 : is_stat1 ? {filt, 6'h00, corrected_out}
                 : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < STORE_DEPTH; i++) begin
        store[i] <= STORE_RESET;
      end
    end else if (wr_store) begin
      store[widx] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Configuration fields
  wire [7:0] mode     = store[BYTE_MODE];
  wire [3:0] s_code   = store[BYTE_GAPS][7:4];
  wire [3:0] t_code   = store[BYTE_GAPS][3:0];
  wire [3:0] src_code = store[BYTE_CTRL][7:4];
  wire [3:0] fshift_r = store[BYTE_FILT][3:0];
  wire [3:0] fshift   = (fshift_r > FILT_MAX) ? FILT_MAX : fshift_r;
  wire [9:0] fixed_gain   = {store[BYTE_HI][1:0], store[BYTE_GAIN]};
  wire [9:0] fixed_offset = {store[BYTE_HI][3:2], store[BYTE_OFS]};
  wire       steer_on = mode[MODE_STEER];
  // Steering owns the shared comparators, so it masks the alarm
  wire       alarm_on = mode[MODE_ALARM] & ~steer_on;

  // Temperature gap count: unknown codes fall back to fixed
  wire [2:0] n_tgap = (t_code == TGAP_4) ? 3'd4
                    : (t_code == TGAP_3) ? 3'd3
                    : (t_code == TGAP_2) ? 3'd2 : 3'd1;
  wire [2:0] n_sgap = (s_code == SGAP_5) ? 3'd5
                    : (s_code == SGAP_4) ? 3'd4
                    : (s_code == SGAP_3) ? 3'd3
                    : (s_code == SGAP_2) ? 3'd2
                    : (s_code == SGAP_1) ? 3'd1 : 3'd0;

  // ==========================================================
  // Temperature filter
  wire signed [16:0] f_diff = $signed({1'b0, temperature_signal, 6'h00})
                            - $signed({1'b0, filt});
  wire signed [16:0] f_step = f_diff >>> fshift;
  wire        [15:0] next_filt = filt_primed
                     ? filt + f_step[15:0]
                     : {temperature_signal, 6'h00};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt        <= FILT_RESET;
      filt_primed <= 1'b0;
    end else if (temp_valid) begin
      filt        <= next_filt;
      filt_primed <= 1'b1;
    end
  end

  wire [9:0] tf = filt[15:6];

  // ==========================================================
  // Temperature gaps: breakpoints, selection, per-gap terms
  logic [9:0]         tbp   [3];
  logic signed [23:0] gterm [4];
  logic signed [23:0] oterm [4];

  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_tbp
      assign tbp[k] = {store[TBP_BASE + 2*k][1:0],
                       store[TBP_BASE + 2*k + 1]};
    end
  endgenerate

  // Highest passed breakpoint wins; ascending breakpoints assumed
  wire [1:0] t_gap = (n_tgap > 3'd3 && tf >= tbp[2]) ? 2'd3
                   : (n_tgap > 3'd2 && tf >= tbp[1]) ? 2'd2
                   : (n_tgap > 3'd1 && tf >= tbp[0]) ? 2'd1
                   : 2'd0;

  generate
    for (k = 0; k < 4; k++) begin : g_tterm
      wire [7:0]         msb  = store[TC_BASE + 3*k + 2];
      wire signed [11:0] gc   = {msb[3:0], store[TC_BASE + 3*k]};
      wire signed [11:0] oc   = {msb[7:4], store[TC_BASE + 3*k + 1]};
      wire [9:0]         lo   = tbp[(k == 0) ? 0 : k - 1];
      wire [9:0]         hi   = (k == 0 || k == 3) ? tf : tbp[(k == 3) ? 2 : k];
      wire               live = n_tgap > 3'd1;
      wire               cur  = (k == 0) ? (t_gap == 2'd0)
                                         : (t_gap == 2'(k));
      wire               past = (k != 0) && (t_gap > 2'(k));
      // Gap 1 is negative of coeff times (T1 - temp); later gaps add
      wire signed [11:0] dt   = !live ? 12'sh000
                              : cur   ? $signed({2'b00, tf}) - $signed({2'b00, lo})
                              : past  ? $signed({2'b00, hi}) - $signed({2'b00, lo})
                              : 12'sh000;
      assign gterm[k] = gc * dt;
      assign oterm[k] = oc * dt;
    end
  endgenerate

  wire signed [25:0] gsum = 26'(gterm[0]) + 26'(gterm[1])
                          + 26'(gterm[2]) + 26'(gterm[3]);
  wire signed [25:0] osum = 26'(oterm[0]) + 26'(oterm[1])
                          + 26'(oterm[2]) + 26'(oterm[3]);
  // Coefficients carry ten fraction bits like the slopes
  wire signed [25:0] graw = $signed({16'h0000, fixed_gain})
                          + (gsum >>> FRAC_BITS);
  wire signed [25:0] oraw = $signed({16'h0000, fixed_offset})
                          + (osum >>> FRAC_BITS);

  function automatic logic [9:0] sat10(input logic signed [25:0] v);
    if (v < 0) begin
      return 10'h000;
    end else if (v > 26'sh00003FF) begin
      return 10'h3FF;
    end else begin
      return v[9:0];
    end
  endfunction

  wire [9:0] next_gain   = sat10(graw);
  wire [9:0] next_offset = sat10(oraw);

  // ==========================================================
  // Signal correction
  logic [9:0]         sbp  [5];
  logic signed [11:0] slp  [5];
  logic [9:0]         sord [5];

  generate
    for (k = 0; k < 5; k++) begin : g_seg
      localparam int B = SIG_BASE + SIG_STRIDE * k;
      assign sbp[k]  = {store[B][1:0], store[B + 1]};
      assign slp[k]  = {store[B + 3][3:0], store[B + 2]};
      assign sord[k] = {store[B + 4][1:0], store[B + 5]};
    end
  endgenerate

  wire [9:0] sig = amplifier_signal;
  wire [2:0] s_seg = (n_sgap > 3'd4 && sig >= sbp[4]) ? 3'd4
                   : (n_sgap > 3'd3 && sig >= sbp[3]) ? 3'd3
                   : (n_sgap > 3'd2 && sig >= sbp[2]) ? 3'd2
                   : (n_sgap > 3'd1 && sig >= sbp[1]) ? 3'd1
                   : 3'd0;
  // First range has no breakpoint: signal is used directly
  wire [9:0]         s_base = (s_seg == 3'd0) ? 10'h000 : sbp[s_seg];
  wire signed [11:0] s_dlt  = $signed({2'b00, sig}) - $signed({2'b00, s_base});
  wire signed [23:0] s_prod = s_dlt * slp[s_seg];
  wire signed [25:0] s_raw  = 26'(s_prod >>> FRAC_BITS)
                            + $signed({16'h0000, sord[s_seg]});
  wire [9:0] s_corr = (mode[MODE_DIG] && n_sgap != 3'd0) ? sat10(s_raw) : sig;

  // ==========================================================
  // Source mux, alarm clamp, level steering
  wire [9:0] src = (src_code == SRC_TEMP) ? temperature_signal
                 : (src_code == SRC_AMP)  ? amplifier_signal
                 : (src_code == SRC_VOUT) ? voltage_output_signal
                 : (src_code == SRC_AUX1) ? aux_one_level
                 : (src_code == SRC_AUX2) ? aux_two_level
                 : ground_reference_signal;
  wire [7:0] lvl      = src[9:2];
  wire [7:0] low_trig = store[ALM_BASE];
  wire [7:0] low_out  = store[ALM_BASE + 1];
  wire [7:0] hi_trig  = store[ALM_BASE + 2];
  wire [7:0] hi_out   = store[ALM_BASE + 3];
  wire       alm_low  = alarm_on & (lvl < low_trig);
  wire       alm_high = alarm_on & (lvl > hi_trig);
  wire [9:0] next_out = alm_low  ? {low_out, 2'b00}
                      : alm_high ? {hi_out, 2'b00}
                      : s_corr;
  // Steering reuses the first three alarm bytes as thresholds
  wire [1:0] st_code  = 2'(lvl > low_trig) + 2'(lvl > low_out)
                      + 2'(lvl > hi_trig);

  // ==========================================================
  // Output registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_dac          <= 10'h000;
      offset_dac        <= 10'h000;
      coarse_gain_sel   <= 3'h0;
      coarse_offset_sel <= 5'h00;
      corrected_out     <= 10'h000;
      alarm_active      <= 1'b0;
      aux_pin_one_out   <= 1'b0;
      aux_pin_two_out   <= 1'b0;
      aux_pin_one_oe    <= 1'b0;
      aux_pin_two_oe    <= 1'b0;
    end else begin
      gain_dac          <= next_gain;
      offset_dac        <= next_offset;
      coarse_gain_sel   <= store[BYTE_COARSE][2:0];
      coarse_offset_sel <= store[BYTE_COARSE][7:3];
      corrected_out     <= next_out;
      alarm_active      <= alm_low | alm_high;
      aux_pin_one_out   <= steer_on & st_code[0];
      aux_pin_two_out   <= steer_on & st_code[1];
      aux_pin_one_oe    <= steer_on;
      aux_pin_two_oe    <= steer_on;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_low_hit;
    alarm_on && lvl < low_trig;
  endsequence
  sequence s_high_hit;
    alarm_on && lvl > hi_trig && !(lvl < low_trig);
  endsequence
  sequence s_apb_bad;
    psel && !penable && !(in_store || is_stat0 || is_stat1)
      ##1 psel && penable && $stable(paddr);
  endsequence

  a_filter_follow: assert property (
    temp_valid && filt_primed && fshift == 4'h0
      |=> filt == {$past(temperature_signal), 6'h00})
    else $error("filter with zero shift did not track sample");
  a_gain_fixed: assert property (
    n_tgap == 3'd1 |=> gain_dac == $past(fixed_gain))
    else $error("fixed gain mode gave wrong gain code");
  a_offset_fixed: assert property (
    n_tgap == 3'd1 |=> offset_dac == $past(fixed_offset))
    else $error("fixed offset mode gave wrong offset code");
  a_coarse_fields: assert property (
    ##1 coarse_gain_sel == $past(store[BYTE_COARSE][2:0])
      && coarse_offset_sel == $past(store[BYTE_COARSE][7:3]))
    else $error("coarse selections do not follow byte 2");
  a_alarm_low: assert property (
    s_low_hit |=> corrected_out == {$past(low_out), 2'b00} && alarm_active)
    else $error("low alarm did not force low output");
  a_alarm_high: assert property (
    s_high_hit |=> corrected_out == {$past(hi_out), 2'b00} && alarm_active)
    else $error("high alarm did not force high output");
  a_steer_excl: assert property (
    steer_on |=> !alarm_active && aux_pin_one_oe && aux_pin_two_oe)
    else $error("steering active together with alarm");
  a_steer_pins: assert property (
    steer_on |=> {aux_pin_two_out, aux_pin_one_out} == $past(st_code))
    else $error("steering pins disagree with level code");
  a_sig_fixed: assert property (
    !alarm_on && n_sgap == 3'd0 |=> corrected_out == $past(sig))
    else $error("fixed signal mode altered the signal");
  a_gain_range: assert property (
    graw > 26'sh00003FF |=> gain_dac == 10'h3FF)
    else $error("gain code did not saturate high");
  a_apb_error: assert property (
    s_apb_bad |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not flagged");

  // ==========================================================
  // Decoder, range and idle checks
  // First sample loads directly so the filter skips the climb from zero
  sequence s_first_sample;
    temp_valid && !filt_primed;
  endsequence
  sequence s_store_wr;
    psel && penable && pwrite && in_store;
  endsequence

  a_filter_load: assert property (
    s_first_sample |=> filt == {$past(temperature_signal), 6'h00})
    else $error("first temperature sample not loaded");
  a_filter_hold: assert property (
    !temp_valid |=> $stable(filt))
    else $error("filter moved without a sample");
  a_offset_floor: assert property (
    oraw < 0 |=> offset_dac == 10'h000)
    else $error("offset code did not saturate low");
  a_tgap_first: assert property (
    n_tgap > 3'd1 && tf < tbp[0] |-> t_gap == 2'd0)
    else $error("temperature below first breakpoint left gap one");
  a_seg_first: assert property (
    n_sgap > 3'd1 && sig < sbp[1] |-> s_seg == 3'd0)
    else $error("signal below second breakpoint left range one");
  a_analog_pass: assert property (
    !mode[MODE_DIG] && !alarm_on |=> corrected_out == $past(sig))
    else $error("analog mode altered the signal");
  // Alarm bytes double as steering thresholds, so off must mean quiet
  a_alarm_idle: assert property (
    !alarm_on |=> !alarm_active)
    else $error("alarm flagged while option off");
  a_steer_idle: assert property (
    !steer_on |=> !aux_pin_one_oe && !aux_pin_two_oe
      && !aux_pin_one_out && !aux_pin_two_out)
    else $error("aux pins driven without steering");
  a_store_write: assert property (
    s_store_wr |=> store[$past(widx)] == $past(pwdata[7:0]))
    else $error("store write did not land");
endmodule
`default_nettype wire

// File: logic/scs_pkg.sv
// Purpose: Constants shared by the sensor compensation engine
// Assumes: One stored byte per APB word, byte index times four
// Notes:   Store layout and status offsets are fixed here only
`default_nettype none
package scs_pkg;
  // ==========================================================
  // Bus and store geometry
  localparam int           STORE_DEPTH = 64;
  localparam int           ADDR_W      = 9;
  localparam int           FRAC_BITS   = 10;
  localparam logic [ADDR_W-1:0] ADDR_STAT0 = 9'h100;
  localparam logic [ADDR_W-1:0] ADDR_STAT1 = 9'h104;
  localparam logic [7:0]   STORE_RESET = 8'h00;
  localparam logic [15:0]  FILT_RESET  = 16'h0000;
  localparam logic [3:0]   FILT_MAX    = 4'h6;
  // ==========================================================
  // Stored byte indices
  localparam int BYTE_COARSE = 2;
  localparam int BYTE_GAIN   = 3;
  localparam int BYTE_OFS    = 4;
  localparam int TC_BASE     = 5;   // 4 gaps x (gain lo, ofs lo, msbs)
  localparam int BYTE_HI     = 17;  // [1:0] gain msbs, [3:2] offset msbs
  localparam int TBP_BASE    = 18;  // 3 breakpoints, hi then lo
  localparam int BYTE_MODE   = 24;
  localparam int BYTE_FILT   = 25;
  localparam int BYTE_GAPS   = 26;
  localparam int ALM_BASE    = 27;  // low trig, low out, high trig, high out
  localparam int BYTE_CTRL   = 31;
  localparam int SIG_BASE    = 32;  // 5 segments of 6 bytes
  localparam int SIG_STRIDE  = 6;
  // ==========================================================
  // Mode byte bits
  localparam int MODE_DIG    = 6;
  localparam int MODE_ALARM  = 5;
  localparam int MODE_STEER  = 4;
  // ==========================================================
  // Source select codes
  localparam logic [3:0] SRC_TEMP = 4'h2;
  localparam logic [3:0] SRC_AMP  = 4'h6;
  localparam logic [3:0] SRC_GND  = 4'h0;
  localparam logic [3:0] SRC_VOUT = 4'h3;
  localparam logic [3:0] SRC_AUX1 = 4'h4;
  localparam logic [3:0] SRC_AUX2 = 4'h5;
  // ==========================================================
  // Gap count codes
  localparam logic [3:0] SGAP_FIX = 4'hF;
  localparam logic [3:0] SGAP_1   = 4'hE;
  localparam logic [3:0] SGAP_2   = 4'hC;
  localparam logic [3:0] SGAP_3   = 4'hA;
  localparam logic [3:0] SGAP_4   = 4'h8;
  localparam logic [3:0] SGAP_5   = 4'h6;
  localparam logic [3:0] TGAP_2   = 4'h5;
  localparam logic [3:0] TGAP_3   = 4'h8;
  localparam logic [3:0] TGAP_4   = 4'hB;
endpackage
`default_nettype wire

// File: sim/scs_frontend_model.sv
// Purpose: Far-side model of the bridge front end, digitisers and DAC loop
// Assumes: Levels come from the bench, one temperature sample per request
// Notes:   An undriven aux pin floats, so it shows a changing pattern
`default_nettype none
module scs_frontend_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       convert,
  input  wire logic [9:0] temp_set,
  input  wire logic [9:0] amp_set,
  input  wire logic [9:0] gain_dac,
  input  wire logic       aux_pin_one_out,
  input  wire logic       aux_pin_one_oe,
  input  wire logic       aux_pin_two_out,
  input  wire logic       aux_pin_two_oe,
  output logic            temp_valid,
  output logic      [9:0] temperature_signal,
  output logic      [9:0] amplifier_signal,
  output logic      [9:0] ground_reference_signal,
  output logic      [9:0] voltage_output_signal,
  output logic      [9:0] aux_one_level,
  output logic      [9:0] aux_two_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] drift;
  // ========================================================
  // Digitisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      temp_valid         <= 1'b0;
      temperature_signal <= 10'h000;
      drift              <= 10'h000;
    end else begin
      temp_valid <= convert;
      drift      <= drift + 10'h155;
      if (convert) begin
        temperature_signal <= temp_set;
      end
    end
  end
  assign amplifier_signal        = amp_set;
  assign ground_reference_signal = 10'h000;
  // Crude DAC loop: output follows the gain code
  assign voltage_output_signal   = gain_dac;
  // Floating pin must not look like a stable level
  assign aux_one_level = aux_pin_one_oe ? {10{aux_pin_one_out}} : drift;
  assign aux_two_level = aux_pin_two_oe ? {10{aux_pin_two_out}} : ~drift;
endmodule
`default_nettype wire

// File: sim/tb_sensor_compensation_engine.sv
// Purpose: Self-checking bench for the compensation engine
// Assumes: Zero-wait APB slave, one stored byte per word
// Notes:   Drivers queue expectations, a monitor compares them
`default_nettype none
module tb_sensor_compensation_engine;
  timeunit 1ns;
  timeprecision 1ps;
  import scs_pkg::*;
  typedef struct {int id; logic [31:0] v;} scs_note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [8:0] paddr;
  logic [31:0] pwdata, prdata, rd, er;
  logic tv, convert, alarm_active, p1, p1e, p2, p2e;
  logic [9:0] ts, as, gs, vs, a1, a2, temp_set, amp_set, g, o;
  logic [9:0] gain_dac, offset_dac, corrected_out;
  logic [2:0] cgs;
  logic [4:0] cos;
  int errors, n_checks, cyc;
  scs_note_s q[$];
  scs_note_s n;
  event chk_ev;
  string nm[9] = '{"gain_dac", "offset_dac", "coarse_gain_sel",
    "coarse_offset_sel", "corrected_out", "alarm_active", "aux_pins",
    "prdata", "pslverr"};
  logic [7:0] tc[9] = '{8'h00, 8'h00, 8'h44, 8'hFF, 8'h00, 8'h87,
    8'h00, 8'h00, 8'h4C};
  logic [7:0] sg[12] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00,
    8'h02, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00};
  logic [39:0] tt[4] = '{{TGAP_3, 12'h180, 12'h180, 12'h180},
    {TGAP_3, 12'h210, 12'h21F, 12'h1E0}, {TGAP_3, 12'h310, 12'h3EF,
    12'h010}, {TGAP_2, 12'h3FF, 12'h3FF, 12'h000}};
  // Mode, level, corrected, then alarm or pins {oe1,oe2,pin1,pin2}
  logic [35:0] at[6] = '{{8'h20, 12'h020, 12'h080, 4'h1},
    {8'h20, 12'h3FC, 12'h3C0, 4'h1}, {8'h20, 12'h200, 12'h200, 4'h0},
    {8'h10, 12'h3FC, 12'h3FC, 4'hF}, {8'h10, 12'h060, 12'h060, 4'hE},
    {8'h10, 12'h020, 12'h020, 4'hC}};

  scs_compensation_engine dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_valid(tv), .temperature_signal(ts), .amplifier_signal(as),
    .ground_reference_signal(gs), .voltage_output_signal(vs),
    .aux_one_level(a1), .aux_two_level(a2), .gain_dac(gain_dac),
    .offset_dac(offset_dac), .coarse_gain_sel(cgs),
    .coarse_offset_sel(cos), .corrected_out(corrected_out),
    .alarm_active(alarm_active), .aux_pin_one_out(p1),
    .aux_pin_one_oe(p1e), .aux_pin_two_out(p2), .aux_pin_two_oe(p2e));
  scs_frontend_model fe (.pclk(pclk), .presetn(presetn),
    .convert(convert), .temp_set(temp_set), .amp_set(amp_set),
    .gain_dac(gain_dac), .aux_pin_one_out(p1), .aux_pin_one_oe(p1e),
    .aux_pin_two_out(p2), .aux_pin_two_oe(p2e), .temp_valid(tv),
    .temperature_signal(ts), .amplifier_signal(as),
    .ground_reference_signal(gs), .voltage_output_signal(vs),
    .aux_one_level(a1), .aux_two_level(a2));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ========================================================
  // Bus and stimulus tasks
  task automatic apb(input logic w, input logic [8:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wb(input int i, input logic [7:0] d);
    apb(1'b1, 9'(i * 4), d);
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic conv(input logic [9:0] t);
    @(posedge pclk);
    temp_set <= t;
    convert  <= 1'b1;
    @(posedge pclk);
    convert  <= 1'b0;
    settle();
  endtask
  task automatic note(input int id, input logic [31:0] v);
    q.push_back('{id, v});
    ->chk_ev;
  endtask
  function automatic logic [31:0] obs(input int id);
    case (id)
      0: obs = 32'(gain_dac);
      1: obs = 32'(offset_dac);
      2: obs = 32'(cgs);
      3: obs = 32'(cos);
      4: obs = 32'(corrected_out);
      5: obs = 32'(alarm_active);
      6: obs = {28'h0, p1e, p2e, p1, p2};
      7: obs = rd;
      default: obs = er;
    endcase
  endfunction
  task automatic summarize();
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ========================================================
  // Monitor and watchdog
  initial begin
    forever begin
      @(chk_ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        n_checks++;
        if (obs(n.id) !== n.v) begin
          errors++;
          $display("unexpected %s exp %h got %h", nm[n.id], n.v,
                   obs(n.id));
        end
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // ========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, convert, temp_set} = '0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    void'($urandom(32'h857da261));
    amp_set = 10'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Alarm bytes stay zero while the option is unused
    settle();
    note(0, 32'h0);
    note(4, 32'(amp_set));
    g = 10'($urandom);
    o = 10'($urandom);
    wb(BYTE_COARSE, 8'hAB);
    wb(BYTE_GAIN, g[7:0]);
    wb(BYTE_OFS, o[7:0]);
    wb(BYTE_HI, {4'h0, o[9:8], g[9:8]});
    settle();
    note(0, 32'(g));
    note(1, 32'(o));
    note(2, 32'h3);
    note(3, 32'h15);
    apb(1'b0, ADDR_STAT0, 8'h00);
    note(7, {6'h0, o, 6'h0, g});
    apb(1'b0, 9'h008, 8'h00);
    note(7, 32'hAB);
    apb(1'b0, 9'h180, 8'h00);
    note(8, 32'h1);
    note(7, 32'h0);
    wb(BYTE_GAIN, 8'h00);
    wb(BYTE_OFS, 8'h00);
    wb(BYTE_HI, 8'h0A);
    wb(TBP_BASE, 8'h02);
    wb(TBP_BASE + 1, 8'h00);
    wb(TBP_BASE + 2, 8'h03);
    wb(TBP_BASE + 3, 8'h00);
    for (int i = 0; i < 9; i++) wb(TC_BASE + i, tc[i]);
    for (int i = 0; i < 4; i++) begin
      wb(BYTE_GAPS, {4'h0, tt[i][39:36]});
      conv(tt[i][33:24]);
      note(0, 32'(tt[i][21:12]));
      note(1, 32'(tt[i][9:0]));
    end
    wb(BYTE_FILT, 8'h01);
    conv(10'h200);
    apb(1'b0, ADDR_STAT1, 8'h00);
    note(7, {16'hBFE0, 6'h0, amp_set});
    wb(BYTE_GAPS, 8'hC0);
    wb(BYTE_MODE, 8'h40);
    for (int i = 0; i < 12; i++) wb(SIG_BASE + i, sg[i]);
    amp_set <= 10'h100;
    settle();
    note(4, 32'h100);
    amp_set <= 10'h300;
    settle();
    note(4, 32'h200);
    wb(ALM_BASE, 8'h10);
    wb(ALM_BASE + 1, 8'h20);
    wb(ALM_BASE + 2, 8'hE0);
    wb(ALM_BASE + 3, 8'hF0);
    wb(BYTE_CTRL, {SRC_AMP, 4'h0});
    for (int i = 0; i < 6; i++) begin
      wb(BYTE_MODE, at[i][35:28]);
      amp_set <= at[i][25:16];
      settle();
      note(4, 32'(at[i][13:4]));
      note(5, 32'(at[i][0] & !at[i][32]));
      note(6, at[i][32] ? 32'(at[i][3:0]) : 32'h0);
    end
    // Steering from other sources: temperature sits at 200h, ground at 0
    wb(BYTE_CTRL, {SRC_TEMP, 4'h0});
    settle();
    note(6, 32'hD);
    wb(BYTE_CTRL, {SRC_GND, 4'h0});
    settle();
    note(6, 32'hC);
    settle();
    summarize();
  end
endmodule
`default_nettype wire
